//--- mss_pkg.sv
`default_nettype none
package mss_pkg;
  // System clock
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_CYCLES     = CLK_HZ / 1000;

  // Frame address byte
  localparam int       DIR_BIT     = 7;
  localparam logic [6:0] BURST_ADDR  = 7'h63;
  localparam int       BURST_BYTES = 7;

  // Host link timing, in ns as specified
  localparam int SCLK_HALF_NS              = 500;
  localparam int READ_ADDRESS_DATA_GAP_NS  = 4000;
  localparam int WRITE_WRITE_GAP_NS        = 30000;
  localparam int WRITE_READ_GAP_NS         = 20000;
  localparam int BURST_EXIT_GAP_NS         = 250;

  // Least times round up to whole cycles
  localparam logic [9:0] SCLK_HALF_CYC =
    10'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] READ_ADDRESS_DATA_GAP_CYC =
    10'((READ_ADDRESS_DATA_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] WRITE_WRITE_GAP_CYC =
    10'((WRITE_WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] WRITE_READ_GAP_CYC =
    10'((WRITE_READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BURST_EXIT_GAP_CYC =
    10'((BURST_EXIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Power levels, in ms as specified
  localparam int RUN_FRAME_MS    = 1;
  localparam int REST1_PERIOD_MS = 14;
  localparam int REST2_PERIOD_MS = 68;
  localparam int REST3_PERIOD_MS = 340;
  localparam int DOWN1_MS        = 1000;
  localparam int DOWN2_MS        = 7000;
  localparam int DOWN3_MS        = 410000;

  // Illumination pulse per frame
  localparam int         LED_PULSE_NS  = 1000;
  localparam logic [4:0] LED_PULSE_CYC =
    5'((LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    DS_IDLE  = 2'b00,
    DS_WDATA = 2'b01,
    DS_RDATA = 2'b10,
    DS_HOLD  = 2'b11
  } mss_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_LOW  = 3'b010,
    HS_HIGH = 3'b011,
    HS_RGAP = 3'b100,
    HS_TAIL = 3'b101,
    HS_GAP  = 3'b110
  } mss_host_st_t;
endpackage
`default_nettype wire

//--- mss_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mss_if;
  logic sclk;
  logic mosi;
  logic port_select_low;
  logic miso;
  logic miso_oe;

  modport dev (
    input  sclk,
    input  mosi,
    input  port_select_low,
    output miso,
    output miso_oe
  );

  modport host (
    output sclk,
    output mosi,
    output port_select_low,
    input  miso,
    input  miso_oe
  );
endinterface
`default_nettype wire

//--- mss_dev.sv
`timescale 1ns/1ps
`default_nettype none
module mss_dev
  import mss_pkg::*;
#(
  parameter int MS_CYC    = MS_CYCLES,
  parameter int BURST_LEN = BURST_BYTES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  mss_if.dev              link,
  input  wire logic       motion_i,
  output logic            rd_req_o,
  output logic [6:0]      rd_addr_o,
  output logic [2:0]      rd_idx_o,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o,
  output logic [6:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic [1:0]      rest_level_o,
  output logic            frame_o,
  output logic            illumination_drive_o
);

  localparam int MSW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

  logic [2:0]  sclk_sy_ff;
  logic [1:0]  sel_sy_ff;
  logic [1:0]  mosi_sy_ff;
  logic        sel;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        byte_done;
  logic [7:0]  byte_val;
  mss_dev_st_t st_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  rx_sr_ff;
  logic [7:0]  tx_sr_ff;
  logic [6:0]  addr_ff;
  logic        burst_ff;
  logic [2:0]  idx_ff;
  logic        rd_req_ff;
  logic        miso_ff;
  logic        miso_oe_ff;
  logic        wr_stb_ff;
  logic [7:0]  wr_data_ff;

  // Link pins come from another domain: two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_sy_ff <= 3'h7;
      sel_sy_ff  <= 2'h0;
      mosi_sy_ff <= 2'h0;
    end else begin
      sclk_sy_ff <= {sclk_sy_ff[1:0], link.sclk};
      sel_sy_ff  <= {sel_sy_ff[0], ~link.port_select_low};
      mosi_sy_ff <= {mosi_sy_ff[0], link.mosi};
    end
  end

  assign sel       = sel_sy_ff[1];
  // Clock edges count only while selected
  assign sclk_rise = sel & sclk_sy_ff[1] & ~sclk_sy_ff[2];
  assign sclk_fall = sel & ~sclk_sy_ff[1] & sclk_sy_ff[2];
  assign byte_val  = {rx_sr_ff[6:0], mosi_sy_ff[1]};
  assign byte_done = sclk_rise & (bit_cnt_ff == 3'h7) & (st_ff != DS_HOLD);

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      st_ff <= DS_IDLE;
    end else if (byte_done) begin
      case (st_ff)
        DS_IDLE: begin
          st_ff <= byte_val[DIR_BIT] ? DS_WDATA : DS_RDATA;
        end
        DS_WDATA: begin
          st_ff <= DS_IDLE;
        end
        DS_RDATA: begin
          if (!burst_ff) begin
            st_ff <= DS_IDLE;
          end else if (idx_ff == 3'(BURST_LEN - 1)) begin
            // Burst done: port stays shut until deselect
            st_ff <= DS_HOLD;
          end
        end
        default: begin
          st_ff <= st_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      bit_cnt_ff <= 3'h0;
    end else if (sclk_rise && st_ff != DS_HOLD) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sr_ff <= 8'h00;
    end else if (sclk_rise) begin
      rx_sr_ff <= byte_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff   <= 7'h00;
      burst_ff  <= 1'b0;
      idx_ff    <= 3'h0;
      rd_req_ff <= 1'b0;
    end else begin
      rd_req_ff <= 1'b0;
      if (!sel) begin
        burst_ff <= 1'b0;
        idx_ff   <= 3'h0;
      end else if (byte_done && st_ff == DS_IDLE) begin
        addr_ff   <= byte_val[6:0];
        burst_ff  <= !byte_val[DIR_BIT] && byte_val[6:0] == BURST_ADDR;
        idx_ff    <= 3'h0;
        rd_req_ff <= !byte_val[DIR_BIT];
      end else if (byte_done && st_ff == DS_RDATA && burst_ff &&
                   idx_ff != 3'(BURST_LEN - 1)) begin
        // No gap between burst bytes: fetch the next at once
        idx_ff    <= idx_ff + 3'h1;
        rd_req_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sr_ff <= 8'h00;
      miso_ff  <= 1'b0;
    end else if (rd_req_ff) begin
      tx_sr_ff <= rd_data_i;
    end else if (sclk_fall && st_ff == DS_RDATA) begin
      miso_ff  <= tx_sr_ff[7];
      tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
    end
  end

  // Drive only inside a host-started read while selected
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= (st_ff == DS_RDATA);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_stb_ff <= byte_done && st_ff == DS_WDATA;
      if (byte_done && st_ff == DS_WDATA) begin
        wr_data_ff <= byte_val;
      end
    end
  end

  assign link.miso    = miso_ff;
  assign link.miso_oe = miso_oe_ff;
  assign rd_req_o     = rd_req_ff;
  assign rd_addr_o    = addr_ff;
  assign rd_idx_o     = idx_ff;
  assign wr_stb_o     = wr_stb_ff;
  assign wr_addr_o    = addr_ff;
  assign wr_data_o    = wr_data_ff;

  // Power sequencing runs on a millisecond tick so the
  // 410 s threshold fits in a narrow counter
  logic [MSW-1:0] ms_cnt_ff;
  logic           ms_tick;
  logic [18:0]    idle_ms_ff;
  logic [18:0]    frame_ms_ff;
  logic [18:0]    period_ms;
  logic [1:0]     nxt_level;
  logic [1:0]     level_ff;
  logic           frame_ff;
  logic [4:0]     led_cnt_ff;
  logic           led_ff;

  assign ms_tick = (ms_cnt_ff == MSW'(MS_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_ff <= '0;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || motion_i) begin
      idle_ms_ff <= 19'h00000;
    end else if (ms_tick && idle_ms_ff < 19'(DOWN3_MS)) begin
      idle_ms_ff <= idle_ms_ff + 19'h00001;
    end
  end

  always_comb begin
    if (idle_ms_ff >= 19'(DOWN3_MS)) begin
      nxt_level = 2'h3;
    end else if (idle_ms_ff >= 19'(DOWN2_MS)) begin
      nxt_level = 2'h2;
    end else if (idle_ms_ff >= 19'(DOWN1_MS)) begin
      nxt_level = 2'h1;
    end else begin
      nxt_level = 2'h0;
    end
  end

  always_comb begin
    case (level_ff)
      2'h1:    period_ms = 19'(REST1_PERIOD_MS);
      2'h2:    period_ms = 19'(REST2_PERIOD_MS);
      2'h3:    period_ms = 19'(REST3_PERIOD_MS);
      default: period_ms = 19'(RUN_FRAME_MS);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= 2'h0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  // Motion restarts the frame clock at run rate
  always_ff @(posedge clk_i) begin
    if (rst_i || motion_i) begin
      frame_ms_ff <= 19'h00000;
      frame_ff    <= 1'b0;
    end else begin
      frame_ff <= 1'b0;
      if (ms_tick) begin
        if (frame_ms_ff >= period_ms - 19'h00001) begin
          frame_ms_ff <= 19'h00000;
          frame_ff    <= 1'b1;
        end else begin
          frame_ms_ff <= frame_ms_ff + 19'h00001;
        end
      end
    end
  end

  // Light only for a short pulse per frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_cnt_ff <= 5'h00;
      led_ff     <= 1'b0;
    end else if (frame_ff) begin
      led_cnt_ff <= LED_PULSE_CYC - 5'h01;
      led_ff     <= 1'b1;
    end else if (led_cnt_ff != 5'h00) begin
      led_cnt_ff <= led_cnt_ff - 5'h01;
    end else begin
      led_ff     <= 1'b0;
    end
  end

  assign rest_level_o         = level_ff;
  assign frame_o              = frame_ff;
  assign illumination_drive_o = led_ff;
endmodule
`default_nettype wire

//--- mss_host.sv
`timescale 1ns/1ps
`default_nettype none
module mss_host
  import mss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  mss_if.host             link,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_write_i,
  input  wire logic [6:0] cmd_addr_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic [2:0] cmd_rd_len_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o
);

  mss_host_st_t st_ff;
  logic [9:0]   cnt_ff;
  logic         sel_low_ff;
  logic         sclk_ff;
  logic         mosi_ff;
  logic [7:0]   tx_sr_ff;
  logic [7:0]   rx_sr_ff;
  logic [7:0]   data_ff;
  logic [2:0]   bit_cnt_ff;
  logic [2:0]   len_ff;
  logic         write_ff;
  logic         addr_ph_ff;
  logic         rsp_valid_ff;
  logic [7:0]   rsp_data_ff;
  logic [1:0]   miso_sy_ff;

  assign cmd_ready_o = (st_ff == HS_IDLE);

  // Device output is a pin: two flops; it settles long before the rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_sy_ff <= 2'h0;
    end else begin
      miso_sy_ff <= {miso_sy_ff[0], link.miso};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff        <= HS_IDLE;
      cnt_ff       <= 10'h000;
      sel_low_ff   <= 1'b1;
      sclk_ff      <= 1'b1;
      mosi_ff      <= 1'b0;
      tx_sr_ff     <= 8'h00;
      rx_sr_ff     <= 8'h00;
      data_ff      <= 8'h00;
      bit_cnt_ff   <= 3'h0;
      len_ff       <= 3'h0;
      write_ff     <= 1'b0;
      addr_ph_ff   <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (cnt_ff != 10'h000) begin
        cnt_ff <= cnt_ff - 10'h001;
      end
      case (st_ff)
        HS_IDLE: begin
          if (cmd_valid_i) begin
            // Each command gets its own select frame
            sel_low_ff <= 1'b0;
            tx_sr_ff   <= {cmd_write_i, cmd_addr_i};
            data_ff    <= cmd_data_i;
            write_ff   <= cmd_write_i;
            len_ff     <= (cmd_rd_len_i == 3'h0) ? 3'h1 : cmd_rd_len_i;
            addr_ph_ff <= 1'b1;
            bit_cnt_ff <= 3'h0;
            cnt_ff     <= SCLK_HALF_CYC - 10'h001;
            st_ff      <= HS_LEAD;
          end
        end
        HS_LEAD, HS_RGAP: begin
          if (cnt_ff == 10'h000) begin
            sclk_ff  <= 1'b0;
            mosi_ff  <= tx_sr_ff[7];
            tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
            cnt_ff   <= SCLK_HALF_CYC - 10'h001;
            st_ff    <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (cnt_ff == 10'h000) begin
            // Device output is stable since the last fall
            sclk_ff  <= 1'b1;
            rx_sr_ff <= {rx_sr_ff[6:0], miso_sy_ff[1]};
            cnt_ff   <= SCLK_HALF_CYC - 10'h001;
            st_ff    <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (cnt_ff == 10'h000) begin
            cnt_ff     <= SCLK_HALF_CYC - 10'h001;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff != 3'h7) begin
              sclk_ff  <= 1'b0;
              mosi_ff  <= tx_sr_ff[7];
              tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
              st_ff    <= HS_LOW;
            end else if (addr_ph_ff && write_ff) begin
              addr_ph_ff <= 1'b0;
              sclk_ff    <= 1'b0;
              mosi_ff    <= data_ff[7];
              tx_sr_ff   <= {data_ff[6:0], 1'b0};
              st_ff      <= HS_LOW;
            end else if (addr_ph_ff) begin
              addr_ph_ff <= 1'b0;
              tx_sr_ff   <= 8'h00;
              cnt_ff     <= READ_ADDRESS_DATA_GAP_CYC - 10'h001;
              st_ff      <= HS_RGAP;
            end else if (write_ff) begin
              // Hold select past the write; covers both spacings
              cnt_ff <= WRITE_WRITE_GAP_CYC - 10'h001;
              st_ff  <= HS_TAIL;
            end else begin
              rsp_valid_ff <= 1'b1;
              rsp_data_ff  <= rx_sr_ff;
              len_ff       <= len_ff - 3'h1;
              if (len_ff != 3'h1) begin
                sclk_ff  <= 1'b0;
                mosi_ff  <= 1'b0;
                st_ff    <= HS_LOW;
              end else begin
                st_ff <= HS_TAIL;
              end
            end
          end
        end
        HS_TAIL: begin
          if (cnt_ff == 10'h000) begin
            sel_low_ff <= 1'b1;
            cnt_ff     <= BURST_EXIT_GAP_CYC - 10'h001;
            st_ff      <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (cnt_ff == 10'h000) begin
            st_ff <= HS_IDLE;
          end
        end
        default: begin
          st_ff <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk            = sclk_ff;
  assign link.mosi            = mosi_ff;
  assign link.port_select_low = sel_low_ff;
  assign rsp_valid_o          = rsp_valid_ff;
  assign rsp_data_o           = rsp_data_ff;
endmodule
`default_nettype wire

//--- mss_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mss_link_checker (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic port_select_low,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic wr_stb_o,
  input  wire logic rd_req_o,
  input  wire logic frame_o,
  input  wire logic illumination_drive_o
);
  logic       sclk_d_ff;
  logic [2:0] since_fall_ff;

  // Age of the last serial clock fall, saturating
  always_ff @(posedge clk_i) begin
    sclk_d_ff <= sclk;
    if (rst_i || (sclk_d_ff && !sclk)) begin
      since_fall_ff <= 3'h0;
    end else if (since_fall_ff != 3'h7) begin
      since_fall_ff <= since_fall_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence light_pulse;
    $rose(illumination_drive_o) ##19 illumination_drive_o
      ##1 !illumination_drive_o;
  endsequence

  sequence deselect_hold;
    port_select_low [*5];
  endsequence

  desel_release_a: assert property ($rose(port_select_low) |-> ##[1:3] !miso_oe)
    else $error("output still driven after deselect");
  desel_quiet_a: assert property (port_select_low [*4] |-> !miso_oe)
    else $error("output driven while deselected");
  select_first_a: assert property (miso_oe |-> !$past(port_select_low, 4))
    else $error("output driven without prior select");
  write_framed_a: assert property (wr_stb_o |-> !$past(port_select_low, 2))
    else $error("write seen outside a select frame");
  read_framed_a: assert property (rd_req_o |-> !$past(port_select_low, 2))
    else $error("read request outside a select frame");
  out_on_fall_a: assert property (
    miso_oe && $past(miso_oe) && $changed(miso) |-> since_fall_ff <= 3'h4)
    else $error("output bit changed away from a clock fall");
  mosi_steady_a: assert property (
    $rose(sclk) && !port_select_low |-> $stable(mosi))
    else $error("input data moved at a rising clock");
  clock_idle_a: assert property (port_select_low |-> sclk)
    else $error("serial clock low while deselected");
  clock_framed_a: assert property ($changed(sclk) |-> !port_select_low)
    else $error("serial clock moved outside a frame");
  light_pulse_a: assert property (frame_o |=> light_pulse)
    else $error("illumination pulse shape wrong");
  exit_gap_a: assert property ($rose(port_select_low) |-> deselect_hold)
    else $error("deselect gap too short");
endmodule
`default_nettype wire

//--- motion_sensor_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module motion_sensor_serial_port_tb;
  import mss_pkg::*;
  localparam int MS = 25;
  logic       clk_i, rst_i, motion_i, cmd_valid, cmd_ready, cmd_write;
  logic       rsp_valid, rd_req, wr_stb, frame, illum, b_stb;
  logic [6:0] cmd_addr, rd_addr, wr_addr, b_addr;
  logic [7:0] cmd_data, rsp_data, rd_data, wr_data, b_data;
  logic [2:0] cmd_len, rd_idx;
  logic [1:0] rest_level;
  logic [15:0] mosi_sr, miso_sr;
  logic [7:0] addr_sr;
  int         n_errors, cmp_count, b_cnt, g, n_bits;

  mss_if link();
  mss_if lb();
  mss_host i_mss_host (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .cmd_rd_len_i(cmd_len), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  mss_dev #(.MS_CYC(MS)) i_mss_dev (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .motion_i(motion_i), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .rd_idx_o(rd_idx), .rd_data_i(rd_data),
    .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rest_level_o(rest_level), .frame_o(frame),
    .illumination_drive_o(illum));
  // Second device faces the bench, which breaks framing on purpose
  mss_dev #(.MS_CYC(MS)) i_mss_dev_b (.clk_i(clk_i), .rst_i(rst_i),
    .link(lb), .motion_i(1'b0), .rd_req_o(), .rd_addr_o(), .rd_idx_o(),
    .rd_data_i(8'h00), .wr_stb_o(b_stb), .wr_addr_o(b_addr),
    .wr_data_o(b_data), .rest_level_o(), .frame_o(),
    .illumination_drive_o());
  mss_link_checker i_mss_link_checker (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(link.sclk), .mosi(link.mosi),
    .port_select_low(link.port_select_low), .miso(link.miso),
    .miso_oe(link.miso_oe), .wr_stb_o(wr_stb), .rd_req_o(rd_req),
    .frame_o(frame), .illumination_drive_o(illum));

  function automatic logic [7:0] exp_rd(input logic [6:0] a,
                                        input logic [2:0] i);
    return {a[4:0], i} ^ 8'h5A;
  endfunction
  assign rd_data = exp_rd(rd_addr, rd_idx);

  always @(posedge link.sclk) begin
    if (!link.port_select_low) begin
      mosi_sr = {mosi_sr[14:0], link.mosi};
      miso_sr = {miso_sr[14:0], link.miso};
      // Burst data overruns the 16-bit window: keep the address apart
      if (n_bits < 8) addr_sr = {addr_sr[6:0], link.mosi};
      n_bits++;
    end
  end
  always @(posedge clk_i) begin
    if (b_stb === 1'b1) begin
      b_cnt++;
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic flag(input int sel);
    case (sel)
      0: return cmd_ready === 1'b1;
      1: return wr_stb === 1'b1;
      2: return rsp_valid === 1'b1;
      3: return rest_level === 2'h1;
      4: return rest_level === 2'h0;
      default: return frame === 1'b1;
    endcase
  endfunction
  task automatic await(input int sel, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(negedge clk_i);
      if (flag(sel)) return;
    end
    n_errors++;
    $display("ERROR wait %0d expected 1 seen 0", sel);
    wrap_up();
  endtask
  task automatic host_cmd(input logic wr, input logic [6:0] a,
                          input logic [7:0] d, input logic [2:0] n);
    await(0, 3000);
    mosi_sr = '0;
    miso_sr = '0;
    addr_sr = '0;
    n_bits = 0;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_data = d;
    cmd_len = n;
    @(negedge clk_i);
    cmd_valid = 1'b0;
    if (wr) begin
      await(1, 3000);
      check("write addr", 16'(wr_addr), 16'(a));
      check("write data", 16'(wr_data), 16'(d));
      check("wire write", mosi_sr, {1'b1, a, d});
    end else begin
      for (int i = 0; i < n; i++) begin
        await(2, 3000);
        check("read byte", 16'(rsp_data), 16'(exp_rd(a, 3'(i))));
      end
      check("wire addr", 16'(addr_sr), {9'h000, a});
      check("wire data", 16'(miso_sr[7:0]), 16'(exp_rd(a, n - 3'h1)));
    end
  endtask
  task automatic bb_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      lb.sclk = 1'b0;
      lb.mosi = v[i];
      repeat (4) @(negedge clk_i);
      lb.sclk = 1'b1;
      repeat (4) @(negedge clk_i);
    end
  endtask
  task automatic frame_gap();
    await(5, 1000);
    for (g = 1; g < 2000; g++) begin
      @(negedge clk_i);
      if (frame === 1'b1) break;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, motion_i, cmd_valid, cmd_write} = 4'h8;
    {cmd_addr, cmd_data, cmd_len} = '0;
    {lb.sclk, lb.port_select_low, lb.mosi} = 3'h6;
    {n_errors, cmp_count, b_cnt} = '0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check("level after reset", 16'(rest_level), 16'h0000);
    host_cmd(1'b1, 7'h15, 8'hA6, 3'h1);
    host_cmd(1'b1, 7'h7F, 8'h01, 3'h1);
    host_cmd(1'b0, 7'h2A, 8'h00, 3'h1);
    host_cmd(1'b0, 7'h00, 8'h00, 3'h1);
    host_cmd(1'b0, BURST_ADDR, 8'h00, 3'(BURST_BYTES));
    host_cmd(1'b0, 7'h2A, 8'h00, 3'h1);
    // Shared-bus noise while deselected
    bb_byte(8'h81);
    bb_byte(8'h55);
    check("idle strobes", 16'(b_cnt), 16'h0000);
    check("idle drive", 16'(lb.miso_oe), 16'h0000);
    lb.port_select_low = 1'b0;
    repeat (4) @(negedge clk_i);
    bb_byte(8'h8C);
    lb.port_select_low = 1'b1;
    lb.mosi = ~lb.mosi;
    repeat (20) @(negedge clk_i);
    check("aborted write", 16'(b_cnt), 16'h0000);
    lb.port_select_low = 1'b0;
    repeat (4) @(negedge clk_i);
    bb_byte(8'h8C);
    bb_byte(8'h3E);
    repeat (10) @(negedge clk_i);
    lb.port_select_low = 1'b1;
    lb.mosi = ~lb.mosi;
    repeat (4) @(negedge clk_i);
    check("retry count", 16'(b_cnt), 16'h0001);
    check("retry data", {1'b0, b_addr, b_data}, 16'h0C3E);
    await(3, 30000);
    frame_gap();
    frame_gap();
    check("rest frame gap", 16'(g), 16'(REST1_PERIOD_MS * MS));
    motion_i = 1'b1;
    @(negedge clk_i);
    motion_i = 1'b0;
    await(4, 40);
    frame_gap();
    frame_gap();
    check("run frame gap", 16'(g), 16'(RUN_FRAME_MS * MS));
    wrap_up();
  end
endmodule
`default_nettype wire
